// *** src/bus_cycle_seq.sv ***
`timescale 1ns/1ps
module bus_cycle_seq
	import seq_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	input  wire logic [1:0]  req_kind,
	input  wire logic [15:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	output logic             req_ready_q,
	output logic             rsp_valid_q,
	output logic [7:0]       rsp_data_q,
	output logic             ale_q,
	output logic             program_store_strobe_n_q,
	output logic             rd_n_q,
	output logic             wr_n_q,
	input  wire logic [7:0]  multiplexed_low_port_in,
	output logic [7:0]       multiplexed_low_port_out_q,
	output logic             multiplexed_low_port_oe_q,
	output logic [7:0]       upper_address_port_q,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	output logic             isp_mode_q,
	output logic [7:0]       ctrl_q,
	input  wire logic [7:0]  gport_wdata,
	input  wire logic [7:0]  gport_pins_in,
	output logic [7:0]       gport_pins_out_q,
	output logic [7:0]       gport_rdata
);

	// =========================================================
	// Bus cycle sequencer
	seq_state_t st_q, st_d;
	cyc_kind_t  kind_q, kind_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] lo_addr_q, lo_addr_d, wdata_q, wdata_d;
	logic [7:0] hi_d, lo_out_d, rdata_d;
	logic       ale_d, program_store_strobe_d, rd_d, wr_d, oe_d, rdy_d, rsp_d;
	logic       first_gap;

	// Next state and registered pin values; all state lives in plain
	// edge flops, so a stopped clock loses nothing
	always_comb
	begin
		st_d      = st_q;
		kind_d    = kind_q;
		cnt_d     = cnt_q;
		lo_addr_d = lo_addr_q;
		wdata_d   = wdata_q;
		hi_d      = upper_address_port_q;
		rdata_d   = rsp_data_q;
		rsp_d     = 1'b0;
		unique case (st_q)
			ST_IDLE:
				if (req_valid)
				begin
					st_d      = ST_ADDR;
					kind_d    = cyc_kind_t'(req_kind);
					lo_addr_d = req_addr[7:0];
					hi_d      = req_addr[15:8];
					wdata_d   = req_wdata;
					cnt_d     = ALE_CYC - 3'h1;
				end
			ST_ADDR:
				if (cnt_q == 3'h0)
				begin
					st_d  = ST_GAP;
					cnt_d = phase_len(ST_GAP, kind_q) - 3'h1;
				end
			ST_GAP:
				if (cnt_q == 3'h0)
				begin
					st_d  = ST_STRB;
					cnt_d = phase_len(ST_STRB, kind_q) - 3'h1;
				end
			ST_STRB:
				if (cnt_q == 3'h0)
				begin
					st_d  = ST_TAIL;
					cnt_d = phase_len(ST_TAIL, kind_q) - 3'h1;
					rsp_d = 1'b1;
					// Latched on the edge that raises the strobe
					if (kind_q != K_WRITE)
						rdata_d = multiplexed_low_port_in;
				end
			ST_TAIL:
				if (cnt_q == 3'h0)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
		// Count down only while staying in the same state
		if (!(st_d != st_q && st_d != ST_IDLE)
			&& st_q != ST_IDLE && cnt_q != 3'h0)
			cnt_d = cnt_q - 3'h1;
	end

	// Pin levels decoded from the next state, so pins leave flops
	always_comb
	begin
		first_gap = (st_d == ST_GAP)
			&& (cnt_d == phase_len(ST_GAP, kind_d) - 3'h1);
		ale_d  = (st_d == ST_ADDR);
		program_store_strobe_d = !(st_d == ST_STRB && kind_d == K_FETCH);
		rd_d   = !(st_d == ST_STRB && kind_d == K_READ);
		wr_d   = !(st_d == ST_STRB && kind_d == K_WRITE);
		rdy_d  = (st_d == ST_IDLE);
		// Address through the latch strobe and one clock beyond
		if (st_d == ST_ADDR || first_gap)
		begin
			oe_d     = 1'b1;
			lo_out_d = lo_addr_d;
		end
		else
		begin
			// Write data brackets the strobe on both sides
			oe_d     = (kind_d == K_WRITE) && (st_d != ST_IDLE);
			lo_out_d = wdata_d;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q                       <= ST_IDLE;
			kind_q                     <= K_FETCH;
			cnt_q                      <= 3'h0;
			lo_addr_q                  <= 8'h00;
			wdata_q                    <= 8'h00;
			upper_address_port_q       <= 8'h00;
			rsp_data_q                 <= 8'h00;
			rsp_valid_q                <= 1'b0;
			req_ready_q                <= 1'b1;
			ale_q                      <= 1'b0;
			program_store_strobe_n_q   <= 1'b1;
			rd_n_q                     <= 1'b1;
			wr_n_q                     <= 1'b1;
			multiplexed_low_port_oe_q  <= 1'b0;
			multiplexed_low_port_out_q <= 8'h00;
		end
		else
		begin
			st_q                       <= st_d;
			kind_q                     <= kind_d;
			cnt_q                      <= cnt_d;
			lo_addr_q                  <= lo_addr_d;
			wdata_q                    <= wdata_d;
			upper_address_port_q       <= hi_d;
			rsp_data_q                 <= rdata_d;
			rsp_valid_q                <= rsp_d;
			req_ready_q                <= rdy_d;
			ale_q                      <= ale_d;
			program_store_strobe_n_q   <= program_store_strobe_d;
			rd_n_q                     <= rd_d;
			wr_n_q                     <= wr_d;
			multiplexed_low_port_oe_q  <= oe_d;
			multiplexed_low_port_out_q <= lo_out_d;
		end
	end

	// =========================================================
	// Programming-mode unlock
	key_state_t ks_q, ks_d;
	logic [7:0] ctrl_d;
	logic       isp_d;

	// Any wrong key byte relocks; a control write leaves the unlock in place
	always_comb
	begin
		ks_d   = ks_q;
		ctrl_d = ctrl_q;
		isp_d  = isp_mode_q;
		if (sfr_wr && sfr_addr == KEY_ADDR)
		begin
			if (sfr_wdata == KEY_FIRST)
				ks_d = KS_HALF;
			else if (sfr_wdata == KEY_SECOND && ks_q == KS_HALF)
				ks_d = KS_OPEN;
			else
				ks_d = KS_LOCK;
		end
		else if (sfr_wr && sfr_addr == CTRL_ADDR && ks_q == KS_OPEN)
		begin
			ctrl_d = sfr_wdata;
			isp_d  = (sfr_wdata == ISP_ENTER);
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			ks_q       <= KS_LOCK;
			ctrl_q     <= CTRL_RESET;
			isp_mode_q <= 1'b0;
		end
		else
		begin
			ks_q       <= ks_d;
			ctrl_q     <= ctrl_d;
			isp_mode_q <= isp_d;
		end
	end

	// =========================================================
	// Machine phase counter and general port unit
	logic [3:0] ph_q, ph_d;
	gport_if    gif();

	always_comb
	begin
		ph_d = (ph_q == PH_STATE_SIX_PHASE_TWO) ? 4'h0 : ph_q + 4'h1;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ph_q <= 4'h0;
		else
			ph_q <= ph_d;
	end

	assign gif.state_five_phase_two     = (ph_q == PH_STATE_FIVE_PHASE_TWO);
	assign gif.state_six_phase_two_end = (ph_q == PH_STATE_SIX_PHASE_TWO);
	assign gif.out_val  = gport_wdata;
	assign gport_rdata  = gif.in_val;

	gport_unit u_gport (
		.mclk       (mclk),
		.nrst       (nrst),
		.gif        (gif.unit),
		.pins_in    (gport_pins_in),
		.pins_out_q (gport_pins_out_q)
	);

	// =========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence s_program_store_strobe_pulse;
		program_store_strobe_n_q ##1 !program_store_strobe_n_q[*3]
			##1 program_store_strobe_n_q;
	endsequence

	sequence s_rd_pulse;
		rd_n_q[*3] ##1 !rd_n_q[*6] ##1 rd_n_q;
	endsequence

	property p_ale_width;
		$rose(ale_q) |-> ale_q[*2] ##1 !ale_q;
	endproperty
	a_ale_width: assert property (p_ale_width)
		else $error("latch strobe width wrong");

	property p_addr_setup;
		$fell(ale_q) |-> $past(multiplexed_low_port_oe_q, 2);
	endproperty
	a_addr_setup: assert property (p_addr_setup)
		else $error("address not driven before latch strobe");

	property p_addr_hold;
		$fell(ale_q) |-> multiplexed_low_port_oe_q
			&& $stable(multiplexed_low_port_out_q);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("low address not held after latch strobe");

	property p_program_store_strobe;
		$fell(ale_q) && kind_q == K_FETCH |-> s_program_store_strobe_pulse;
	endproperty
	a_program_store_strobe: assert property (p_program_store_strobe)
		else $error("program strobe timing wrong");

	property p_rd;
		$fell(ale_q) && kind_q == K_READ |-> s_rd_pulse;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read strobe timing wrong");

	property p_wr_setup;
		$fell(wr_n_q) |-> multiplexed_low_port_oe_q
			&& $past(multiplexed_low_port_oe_q)
			&& $stable(multiplexed_low_port_out_q);
	endproperty
	a_wr_setup: assert property (p_wr_setup)
		else $error("write data not set up");

	property p_wr_hold;
		$rose(wr_n_q) |-> multiplexed_low_port_oe_q
			&& $stable(multiplexed_low_port_out_q);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write data not held");

	property p_upper;
		!req_ready_q && !$past(req_ready_q) |-> $stable(upper_address_port_q);
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper address moved mid cycle");

	property p_capture;
		$rose(program_store_strobe_n_q) |-> rsp_valid_q
			&& rsp_data_q == $past(multiplexed_low_port_in);
	endproperty
	a_capture: assert property (p_capture)
		else $error("fetched byte not captured");

	property p_isp;
		sfr_wr && sfr_addr == CTRL_ADDR && ks_q == KS_OPEN
			&& sfr_wdata == ISP_ENTER |=> isp_mode_q;
	endproperty
	a_isp: assert property (p_isp)
		else $error("programming mode not entered");

	property p_locked;
		ks_q != KS_OPEN |=> $stable(ctrl_q);
	endproperty
	a_locked: assert property (p_locked)
		else $error("control written while locked");

endmodule

// *** inc/seq_pkg.sv ***
// Operation
// - Fully static logic; the clock may stop at either level indefinitely.
// - Fetch address is valid at least one clock before the latch strobe falls.
// - Low address stays on the multiplexed port one clock after strobe falls.
// - Fetched byte is captured before the program store strobe returns high.
// - Upper address port holds steady for the whole memory cycle.
// - Write data is driven at least one clock before the write strobe falls.
// - Write data stays driven one clock after the write strobe rises.
// - General port inputs are sampled at state five phase two.
// - New port outputs appear at the end of state six phase two.
// - Control register writes need key 87h then 59h written first.
// - Once unlocked, writing 03h to control enters programming mode.
package seq_pkg;

	// =========================================================
	// Special register addresses and key values
	localparam logic [7:0] KEY_ADDR   = 8'hf6;
	localparam logic [7:0] CTRL_ADDR  = 8'hbf;
	localparam logic [7:0] KEY_FIRST  = 8'h87;
	localparam logic [7:0] KEY_SECOND = 8'h59;
	localparam logic [7:0] ISP_ENTER  = 8'h03;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// =========================================================
	// Cycle phase lengths, in input clock periods
	localparam logic [2:0] ALE_CYC   = 3'h2;
	localparam logic [2:0] FGAP_CYC  = 3'h1;
	localparam logic [2:0] PROGRAM_STORE_STROBE_CYC  = 3'h3;
	localparam logic [2:0] FTAIL_CYC = 3'h1;
	localparam logic [2:0] RWGAP_CYC = 3'h3;
	localparam logic [2:0] RW_CYC    = 3'h6;
	localparam logic [2:0] RTAIL_CYC = 3'h2;
	localparam logic [2:0] WTAIL_CYC = 3'h1;

	// =========================================================
	// Machine cycle: six states of two phases each
	localparam logic [3:0] PH_STATE_FIVE_PHASE_TWO = 4'h9;
	localparam logic [3:0] PH_STATE_SIX_PHASE_TWO = 4'hb;
	localparam logic [7:0] PORT_RESET = 8'hff;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_GAP  = 5'h04,
		ST_STRB = 5'h08,
		ST_TAIL = 5'h10
	} seq_state_t;

	typedef enum logic [1:0] {
		K_FETCH = 2'h0,
		K_READ  = 2'h1,
		K_WRITE = 2'h2
	} cyc_kind_t;

	typedef enum logic [2:0] {
		KS_LOCK = 3'h1,
		KS_HALF = 3'h2,
		KS_OPEN = 3'h4
	} key_state_t;

	// Length of a sequencer state for a given cycle kind
	function automatic logic [2:0] phase_len(seq_state_t s, cyc_kind_t k);
		logic [2:0] n;
		n = 3'h1;
		unique case (s)
			ST_ADDR: n = ALE_CYC;
			ST_GAP:  n = (k == K_FETCH) ? FGAP_CYC : RWGAP_CYC;
			ST_STRB: n = (k == K_FETCH) ? PROGRAM_STORE_STROBE_CYC : RW_CYC;
			ST_TAIL:
			begin
				if (k == K_FETCH)
					n = FTAIL_CYC;
				else if (k == K_READ)
					n = RTAIL_CYC;
				else
					n = WTAIL_CYC;
			end
			ST_IDLE: n = 3'h1;
		endcase
		return n;
	endfunction

endpackage

// *** inc/gport_if.sv ***
`timescale 1ns/1ps
// Machine-phase strobes and port data between sequencer and port unit
interface gport_if;
	logic       state_five_phase_two;
	logic       state_six_phase_two_end;
	logic [7:0] out_val;
	logic [7:0] in_val;

	modport seq  (output state_five_phase_two, output state_six_phase_two_end, output out_val,
		input in_val);
	modport unit (input state_five_phase_two, input state_six_phase_two_end, input out_val,
		output in_val);
endinterface

// *** src/gport_unit.sv ***
`timescale 1ns/1ps
module gport_unit
	import seq_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       nrst,
	gport_if.unit           gif,
	input  wire logic [7:0] pins_in,
	output logic      [7:0] pins_out_q
);

	// =========================================================
	// Input synchroniser and filter
	logic [7:0] s1_q, s2_q, s3_q, stable_q, in_q;
	logic [7:0] stable_d, in_d, out_d;

	// Accept a change only when stages two and three agree
	always_comb
	begin
		stable_d = stable_q;
		for (int i = 0; i < 8; i++)
			if (s2_q[i] == s3_q[i])
				stable_d[i] = s3_q[i];
		in_d  = gif.state_five_phase_two ? stable_q : in_q;
		out_d = gif.state_six_phase_two_end ? gif.out_val : pins_out_q;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_q       <= PORT_RESET;
			s2_q       <= PORT_RESET;
			s3_q       <= PORT_RESET;
			stable_q   <= PORT_RESET;
			in_q       <= PORT_RESET;
			pins_out_q <= PORT_RESET;
		end
		else
		begin
			s1_q       <= pins_in;
			s2_q       <= s1_q;
			s3_q       <= s2_q;
			stable_q   <= stable_d;
			in_q       <= in_d;
			pins_out_q <= out_d;
		end
	end

	assign gif.in_val = in_q;

	// =========================================================
	// Checks
	property p_sample;
		@(posedge mclk) disable iff (!nrst)
		gif.state_five_phase_two |=> in_q == $past(stable_q);
	endproperty
	a_sample: assert property (p_sample)
		else $error("port input not sampled at state_five_phase_two");

	property p_update;
		@(posedge mclk) disable iff (!nrst)
		!$stable(pins_out_q) |-> $past(gif.state_six_phase_two_end);
	endproperty
	a_update: assert property (p_update)
		else $error("port output changed outside state_six_phase_two end");

endmodule

// *** sim/ext_mem_model.sv ***
`timescale 1ns/1ps
// =========================================================
// External code and data memory behind an address latch
module ext_mem_model
(
	input  wire logic       mclk,
	input  wire logic       slow,
	input  wire logic       ale,
	input  wire logic       program_store_strobe_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [7:0] dev_out,
	input  wire logic       dev_oe,
	input  wire logic [7:0] upper,
	output logic      [7:0] low_port,
	output logic            clash
);
	logic [7:0]  code [0:65535];
	logic [7:0]  data [0:65535];
	logic [7:0]  lat  = 8'h00;
	logic [7:0]  fl   = 8'h00;
	logic [2:0]  cnt  = 3'h0;
	logic [2:0]  hold = 3'h0;
	logic        fet  = 1'b0;
	logic        lo;
	logic        ftc;
	logic        drv;
	logic [15:0] a;

	// Latch, strobe age and hold count, sampled per clock
	always @(posedge mclk)
	begin
		if (ale)
			lat <= dev_out;
		if (!wr_n)
			data[a] <= dev_out;
		cnt <= lo ? cnt + 3'h1 : 3'h0;
		fet <= ftc;
		hold <= lo ? (!program_store_strobe_n ? 3'h1 : 3'h2) : (hold != 0 ? hold - 3'h1 : 3'h0);
		fl <= ~low_port; // Floating bus never repeats the previous clock's value
	end

	// Slow mode answers at the last allowed moment
	assign lo = !program_store_strobe_n || !rd_n;
	assign ftc = lo ? !program_store_strobe_n : fet;
	assign a = {upper, lat};
	assign drv = lo ? cnt >= (!slow ? 3'h0 : !program_store_strobe_n ? 3'h2 : 3'h4) : hold != 0;
	assign low_port = dev_oe ? dev_out : drv ? (ftc ? code[a] : data[a]) : fl;
	assign clash = dev_oe && drv;
endmodule

// *** sim/external_bus_cycle_sequencer_bench.sv ***
`timescale 1ns/1ps
module external_bus_cycle_sequencer_bench import seq_pkg::*;;
	logic        mclk = 1'b0, nrst = 1'b0, run = 1'b1, slow = 1'b0;
	logic        req_valid = 1'b0, sfr_wr = 1'b0;
	logic [1:0]  req_kind = 2'h0;
	logic [15:0] req_addr = 16'h0;
	logic [7:0]  req_wdata = 8'h0, sfr_addr = 8'h0, sfr_wdata = 8'h0;
	logic [7:0]  gport_wdata = 8'hff, gport_pins_in = 8'h00;
	logic        req_ready_q, rsp_valid_q, ale_q, program_store_strobe_n_q;
	logic        rd_n_q, wr_n_q, multiplexed_low_port_oe_q, isp_mode_q, clash;
	logic [7:0]  rsp_data_q, multiplexed_low_port_out_q, upper_address_port_q;
	logic [7:0]  ctrl_q, gport_pins_out_q, gport_rdata, low_port;
	int          n_errors = 0, compares = 0, cyc = 0;

	bus_cycle_seq i_bus_cycle_seq (.mclk(mclk), .nrst(nrst),
		.req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready_q(req_ready_q),
		.rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .ale_q(ale_q),
		.program_store_strobe_n_q(program_store_strobe_n_q),
		.rd_n_q(rd_n_q), .wr_n_q(wr_n_q),
		.multiplexed_low_port_in(low_port),
		.multiplexed_low_port_out_q(multiplexed_low_port_out_q),
		.multiplexed_low_port_oe_q(multiplexed_low_port_oe_q),
		.upper_address_port_q(upper_address_port_q), .sfr_wr(sfr_wr),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.isp_mode_q(isp_mode_q), .ctrl_q(ctrl_q),
		.gport_wdata(gport_wdata), .gport_pins_in(gport_pins_in),
		.gport_pins_out_q(gport_pins_out_q), .gport_rdata(gport_rdata));

	ext_mem_model i_ext_mem_model (.mclk(mclk), .slow(slow), .ale(ale_q),
		.program_store_strobe_n(program_store_strobe_n_q), .rd_n(rd_n_q), .wr_n(wr_n_q),
		.dev_out(multiplexed_low_port_out_q),
		.dev_oe(multiplexed_low_port_oe_q), .upper(upper_address_port_q),
		.low_port(low_port), .clash(clash));

	// =========================================================
	// Clock may be frozen at either level through run
	initial
		forever #5 if (run) mclk = ~mclk;

	// Edge count for phase measurements
	always @(posedge mclk)
		cyc <= cyc + 1;

	// =========================================================
	// Comparison and reporting
	task automatic check(input string nm, input logic [15:0] s, e);
		compares++;
		if (s !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic summarize();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic tmo();
		n_errors++;
		summarize();
	endtask

	// One bus cycle, walked and judged cycle by cycle
	task automatic op(input logic [1:0] k, input logic [15:0] ad,
		input logic [7:0] wd, ex);
		int   c, al, st, f;
		logic s;
		al = 0;
		st = 0;
		f = 0;
		@(negedge mclk);
		req_valid = 1'b1;
		req_kind = k;
		req_addr = ad;
		req_wdata = wd;
		for (c = 0; c < 20 && req_ready_q !== 1'b1; c++)
			@(negedge mclk);
		@(negedge mclk);
		req_valid = 1'b0;
		for (c = 0; c < 20 && rsp_valid_q !== 1'b1; c++)
		begin
			s = k == 2'h0 ? program_store_strobe_n_q : k == 2'h1 ? rd_n_q : wr_n_q;
			check("clash", 16'(clash), 16'h0);
			if (c > 0)
				check("upper", 16'(upper_address_port_q), 16'(ad[15:8]));
			if (ale_q === 1'b1 || c == 2)
				check("addr", {7'h0, multiplexed_low_port_oe_q,
					multiplexed_low_port_out_q}, {8'h1, ad[7:0]});
			if (k == 2'h2 && c == 4)
				check("wdata", {7'h0, multiplexed_low_port_oe_q,
					multiplexed_low_port_out_q}, {8'h1, wd});
			if (ale_q === 1'b1)
				al++;
			if (s === 1'b0)
			begin
				if (st == 0)
					f = c;
				st++;
			end
			@(negedge mclk);
		end
		if (c == 20)
			tmo();
		check("latency", 16'(c), k == 2'h0 ? 16'h6 : 16'hb);
		check("ale width", 16'(al), 16'h2);
		check("strobe width", 16'(st), k == 2'h0 ? 16'h3 : 16'h6);
		check("strobe start", 16'(f), k == 2'h0 ? 16'h3 : 16'h5);
		if (k == 2'h2)
		begin
			check("wdata hold", {7'h0, multiplexed_low_port_oe_q,
				multiplexed_low_port_out_q}, {8'h1, wd});
			check("stored", 16'(i_ext_mem_model.data[ad]), 16'(wd));
		end
		else
			check("rsp", 16'(rsp_data_q), 16'(ex));
		for (c = 0; c < 20 && req_ready_q !== 1'b1; c++)
			@(negedge mclk);
		if (c == 20)
			tmo();
	endtask

	task automatic sfr(input logic [7:0] a, d);
		@(negedge mclk);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask

	// Key order, broken sequences and entry value
	task automatic t_key();
		sfr(CTRL_ADDR, ISP_ENTER);
		check("locked", {7'h0, isp_mode_q, ctrl_q}, 16'h0);
		sfr(KEY_ADDR, KEY_FIRST);
		sfr(KEY_ADDR, 8'h00);
		sfr(KEY_ADDR, KEY_SECOND);
		sfr(CTRL_ADDR, ISP_ENTER);
		check("broken key", {7'h0, isp_mode_q, ctrl_q}, 16'h0);
		sfr(KEY_ADDR, KEY_SECOND);
		sfr(KEY_ADDR, KEY_FIRST);
		sfr(CTRL_ADDR, ISP_ENTER);
		check("reversed key", {7'h0, isp_mode_q, ctrl_q}, 16'h0);
		sfr(KEY_ADDR, KEY_FIRST);
		sfr(KEY_ADDR, KEY_SECOND);
		sfr(CTRL_ADDR, 8'h02);
		check("other value", {7'h0, isp_mode_q, ctrl_q}, 16'h0002);
		sfr(CTRL_ADDR, ISP_ENTER);
		check("enter", {7'h0, isp_mode_q, ctrl_q}, 16'h0103);
	endtask

	// Port updates must keep to the twelve-clock machine cycle
	task automatic t_ports();
		int c, t0, t1;
		@(negedge mclk);
		gport_wdata = 8'h3c;
		for (c = 0; c < 40 && gport_pins_out_q !== 8'h3c; c++)
			@(negedge mclk);
		if (c == 40)
			tmo();
		t0 = cyc;
		gport_wdata = 8'hc3;
		for (c = 0; c < 40 && gport_pins_out_q !== 8'hc3; c++)
			@(negedge mclk);
		if (c == 40)
			tmo();
		check("out phase", 16'((cyc - t0) % 12), 16'h0);
		t1 = cyc;
		gport_pins_in = 8'ha5;
		for (c = 0; c < 40 && gport_rdata !== 8'ha5; c++)
			@(negedge mclk);
		if (c == 40)
			tmo();
		check("in phase", 16'((cyc - t1) % 12), 16'ha);
	endtask

	// =========================================================
	// Main sequence
	initial
	begin
		i_ext_mem_model.code[16'hffff] = 8'h96;
		i_ext_mem_model.code[16'h0000] = 8'h4b;
		i_ext_mem_model.code[16'h1234] = 8'he1;
		repeat (12) @(negedge mclk);
		check("rst ctl", {10'h0, req_ready_q, ale_q, program_store_strobe_n_q,
			rd_n_q, wr_n_q, multiplexed_low_port_oe_q}, 16'h2e);
		check("rst port", {multiplexed_low_port_out_q, upper_address_port_q}, 16'h0);
		check("rst rsp", {7'h0, rsp_valid_q, rsp_data_q}, 16'h0);
		check("rst mode", {7'h0, isp_mode_q, ctrl_q}, 16'h0);
		check("rst gport", {gport_pins_out_q, gport_rdata}, 16'hffff);
		nrst = 1'b1;
		op(2'h0, 16'hffff, 8'h00, 8'h96);
		op(2'h0, 16'h0000, 8'h00, 8'h4b);
		slow = 1'b1; // Far side at its slowest legal answer
		op(2'h0, 16'h1234, 8'h00, 8'he1);
		op(2'h2, 16'h8001, 8'h5a, 8'h00);
		op(2'h1, 16'h8001, 8'h00, 8'h5a);
		slow = 1'b0;
		op(2'h2, 16'h00ff, 8'ha3, 8'h00);
		op(2'h1, 16'h00ff, 8'h00, 8'ha3);
		// Freeze the clock high, then low, in mid cycle
		fork
			op(2'h1, 16'h8001, 8'h00, 8'h5a);
			begin
				repeat (6) @(posedge mclk);
				#1 run = 1'b0;
				#300 run = 1'b1;
				repeat (2) @(negedge mclk);
				#1 run = 1'b0;
				#300 run = 1'b1;
			end
		join
		t_key();
		t_ports();
		summarize();
	end
endmodule
